// File: sll_checker.sv
// Port assertions for the serial latch loader
`timescale 1ns/10ps
`default_nettype none
module sll_checker (
  input wire logic clk,              // Core clock
  input wire logic nrst,             // Reset, active low
  input wire logic load_strobe,      // Load strobe
  input wire logic power_enable,     // Run request
  input wire logic lock_indicator,   // Lock level
  input wire logic [23:0] r_latch,   // R latch
  input wire logic [23:0] n_latch,   // N latch
  input wire logic [23:0] func_latch, // Function latch
  input wire logic counter_reset,    // Counter reset pulse
  input wire logic power_down,       // Power-down state
  input wire logic monitor_output    // Monitor pin
);
  // ****************************************
  // Checks
  // ****************************************
  // Strobe is asynchronous, so several low samples cover the crossing
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_strobe_hold: assert property (
    !load_strobe [*6] |-> $stable(r_latch) && $stable(n_latch)
    && $stable(func_latch)) else $error("latch moved, strobe low");
  a_pdown_follow: assert property (
    $stable(power_enable) [*5] |-> power_down == !power_enable)
    else $error("power_down does not follow enable");
  a_mon_high: assert property (
    (func_latch[6:4] == sll_pkg::MON_HIGH) [*3] |-> monitor_output)
    else $error("monitor not high");
  a_mon_low: assert property (
    (func_latch[6:4] == sll_pkg::MON_LOW) [*3] |-> !monitor_output)
    else $error("monitor not low");
  a_mon_lock: assert property (
    (func_latch[6:4] == sll_pkg::MON_LOCK && $stable(lock_indicator)) [*5]
    |-> monitor_output == lock_indicator) else $error("monitor not lock");
  a_rst_pulse: assert property (
    $rose(counter_reset) |=> counter_reset ##1 !counter_reset)
    else $error("counter reset pulse length");
  a_r_select: assert property (
    $changed(r_latch) |-> r_latch[1:0] == sll_pkg::SEL_R)
    else $error("r_latch took wrong select");
  a_n_select: assert property (
    $changed(n_latch) |-> n_latch[1:0] == sll_pkg::SEL_N)
    else $error("n_latch took wrong select");
  a_f_select: assert property (
    $changed(func_latch) |-> func_latch[1]) else $error("func select");
endmodule // sll_checker
bind sll_top sll_checker i_chk (.clk(clk), .nrst(nrst),
  .load_strobe(load_strobe), .power_enable(power_enable),
  .lock_indicator(lock_indicator), .r_latch(r_latch), .n_latch(n_latch),
  .func_latch(func_latch), .counter_reset(counter_reset),
  .power_down(power_down), .monitor_output(monitor_output));
`default_nettype wire

// File: sll_host.sv
// Host serial port model for the three-wire write port
`timescale 1ns/10ps
`default_nettype none
module sll_host (
  output var logic sclk,       // Serial clock, idle low
  output var logic sdata,      // Serial data
  output var logic load_strobe // Load strobe
);
  // ****************************************
  // Word writer
  // ****************************************
  // Idle levels before any frame
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    load_strobe = 1'b1;
  end
  // Clock runs only in a frame; data flips after it so stale bits differ
  task automatic send(input logic [23:0] w, input logic [7:0] pre,
                      input bit extra, input bit slow);
    logic [31:0] v;
    int n;
    realtime hp;
    v = {pre, w};
    n = extra ? 32 : 24;
    // Slow frames keep to the 20 MHz host ceiling; fast ones stress the
    // crossing with the 30 ns link period
    hp = slow ? 25.0 : 15.0;
    load_strobe = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      if (slow && i % 8 == 7) #100;
      sdata = v[i];
      #(hp) sclk = 1'b1;
      #(hp) sclk = 1'b0;
    end
    #15 load_strobe = 1'b1;
    sdata = ~sdata;
  endtask
endmodule // sll_host
`default_nettype wire

// File: sll_pkg.sv
// Shared constants and carrier types for the serial latch loader
package sll_pkg;
  // ****************************************************************
  // Word format
  // ****************************************************************
  localparam int WORD_BITS = 24;
  localparam int SEL_LSB = 0;
  localparam int SEL_BITS = 2;
  localparam logic [1:0] SEL_R = 2'h0;
  localparam logic [1:0] SEL_N = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  // Monitor select field position inside the function word
  localparam int MON_LSB = 4;
  localparam int MON_BITS = 3;
  localparam logic [2:0] MON_LOCK = 3'h1;
  localparam logic [2:0] MON_LOW = 3'h0;
  localparam logic [2:0] MON_HIGH = 3'h7;
  localparam logic [23:0] LATCH_RST = 24'h000000;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SCLK_MAX_MHZ = 20;
  localparam int CLK_MHZ = 40;
  localparam int RST_PULSE_NS = 50;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RST_PULSE_CNT = 4'(RST_PULSE_CYC);

  // A captured word travelling from the link to the core
  typedef struct packed {
    logic [WORD_BITS-1:0] data;
  } sll_word_s;
endpackage : sll_pkg

// File: sll_top.sv
// Serial latch loader: link shift register, crossing, buffer and latches
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Shift data on each serial clock rise
// - Strobe rise moves word into selected latch
// - Monitor output selectable, includes lock indication
// - Power enable input controls power down
// - Two low bits select target latch
// - Input register keeps working in power down
// - Init write loads function, pulses counter reset
module sll_top (
  input wire logic clk,              // Core clock, 40 MHz
  input wire logic nrst,             // Async reset, active low
  input wire logic sclk,             // Serial clock from host
  input wire logic sdata,            // Serial data from host
  input wire logic load_strobe,      // Load strobe from host
  input wire logic power_enable,     // High runs, low powers down
  input wire logic lock_indicator,   // Lock state from the loop
  output logic [23:0] r_latch,       // R counter latch
  output logic [23:0] n_latch,       // N counter latch
  output logic [23:0] func_latch,    // Function latch
  output logic counter_reset,        // Pulse resetting R and N counters
  output logic power_down,           // Power-down state
  output logic monitor_output        // Selected internal signal
);
  // ****************************************************************
  // Link domain: shift register on the serial clock
  // ****************************************************************
  logic [23:0] shift;
  logic [23:0] next_shift;
  logic [23:0] held;
  logic [23:0] next_held;
  logic tgl;
  logic next_tgl;

  // Shifting keeps running in power-down; older bits fall off the top
  always_comb begin
    next_shift = {shift[22:0], sdata};
  end

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      shift <= 24'h000000;
    end else begin
      shift <= next_shift;
    end
  end

  // Strobe rise captures the word; the toggle flags it to the core.
  // The serial clock may stand during the strobe, so capture is on it.
  always_comb begin
    next_held = shift;
    next_tgl = ~tgl;
  end

  always_ff @(posedge load_strobe or negedge nrst) begin
    if (!nrst) begin
      held <= 24'h000000;
      tgl <= 1'b0;
    end else begin
      held <= next_held;
      tgl <= next_tgl;
    end
  end

  // ****************************************************************
  // Crossing into the core domain
  // ****************************************************************
  logic [2:0] tsync;
  logic [2:0] next_tsync;
  logic [1:0] pe_sync;
  logic [1:0] next_pe_sync;
  logic [1:0] lk_sync;
  logic [1:0] next_lk_sync;
  logic evt;

  always_comb begin
    next_tsync = {tsync[1:0], tgl};
    next_pe_sync = {pe_sync[0], power_enable};
    next_lk_sync = {lk_sync[0], lock_indicator};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsync <= 3'h0;
      pe_sync <= 2'h0;
      lk_sync <= 2'h0;
    end else begin
      tsync <= next_tsync;
      pe_sync <= next_pe_sync;
      lk_sync <= next_lk_sync;
    end
  end

  // Only strobe rises reach the core, so a low strobe changes nothing
  assign evt = tsync[2] ^ tsync[1];

  // ****************************************************************
  // Two-entry buffer; held word is stable long after the toggle
  // ****************************************************************
  sll_pkg::sll_word_s buf_mem [2];
  sll_pkg::sll_word_s next_buf0;
  sll_pkg::sll_word_s next_buf1;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic in_valid;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  sll_pkg::sll_word_s in_word;
  sll_pkg::sll_word_s out_word;
  // Reset pulse counter, declared here because the drain gate reads it
  logic [3:0] pulse_cnt;
  logic [3:0] next_pulse_cnt;

  assign in_valid = evt;
  assign in_word.data = held;
  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_word = buf_mem[0];
  // Core drains only outside a reset pulse so init ordering holds
  assign out_ready = (pulse_cnt == 4'h0);

  always_comb begin
    next_buf0 = buf_mem[0];
    next_buf1 = buf_mem[1];
    next_cnt = cnt;
    if (out_valid && out_ready) begin
      next_buf0 = buf_mem[1];
      next_cnt = next_cnt - 2'h1;
    end
    if (in_valid && in_ready) begin
      if (next_cnt == 2'h0) begin
        next_buf0 = in_word;
      end else begin
        next_buf1 = in_word;
      end
      next_cnt = next_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      cnt <= 2'h0;
    end else begin
      buf_mem[0] <= next_buf0;
      buf_mem[1] <= next_buf1;
      cnt <= next_cnt;
    end
  end

  // ****************************************************************
  // Latches, reset pulse and outputs
  // ****************************************************************
  logic init_armed;
  logic next_init_armed;
  logic [23:0] next_r;
  logic [23:0] next_n;
  logic [23:0] next_f;
  logic next_pd;
  logic next_mon;
  logic [2:0] mon_sel;
  logic [1:0] sel;

  assign sel = out_word.data[sll_pkg::SEL_LSB +: sll_pkg::SEL_BITS];
  assign mon_sel = func_latch[sll_pkg::MON_LSB +: sll_pkg::MON_BITS];

  // Init arms one more pulse on the first N load after it
  always_comb begin
    next_r = r_latch;
    next_n = n_latch;
    next_f = func_latch;
    next_init_armed = init_armed;
    next_pulse_cnt = pulse_cnt - ((pulse_cnt != 4'h0) ? 4'h1 : 4'h0);
    if (out_valid && out_ready) begin
      unique case (sel)
        sll_pkg::SEL_R: next_r = out_word.data;
        sll_pkg::SEL_N: begin
          next_n = out_word.data;
          if (init_armed) begin
            next_pulse_cnt = sll_pkg::RST_PULSE_CNT;
            next_init_armed = 1'b0;
          end
        end
        sll_pkg::SEL_FUNC: next_f = out_word.data;
        sll_pkg::SEL_INIT: begin
          next_f = out_word.data;
          next_pulse_cnt = sll_pkg::RST_PULSE_CNT;
          next_init_armed = 1'b1;
        end
      endcase
    end
    next_pd = ~pe_sync[1];
    unique case (mon_sel)
      sll_pkg::MON_LOCK: next_mon = lk_sync[1];
      sll_pkg::MON_HIGH: next_mon = 1'b1;
      default: next_mon = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_latch <= sll_pkg::LATCH_RST;
      n_latch <= sll_pkg::LATCH_RST;
      func_latch <= sll_pkg::LATCH_RST;
      pulse_cnt <= 4'h0;
      init_armed <= 1'b0;
      power_down <= 1'b1;
      monitor_output <= 1'b0;
    end else begin
      r_latch <= next_r;
      n_latch <= next_n;
      func_latch <= next_f;
      pulse_cnt <= next_pulse_cnt;
      init_armed <= next_init_armed;
      power_down <= next_pd;
      monitor_output <= next_mon;
    end
  end

  assign counter_reset = (pulse_cnt != 4'h0);

endmodule // sll_top
`default_nettype wire

// File: sll_top_tb.sv
// Self-checking bench for the serial latch loader
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module sll_top_tb;
  logic clk, nrst, sclk, sdata, load_strobe, power_enable, lock_indicator;
  logic [23:0] r_latch, n_latch, func_latch, er, en, ef;
  logic counter_reset, power_down, monitor_output;
  int bad_count, samples_checked, cyc;
  bit arm;
  sll_top i_dut (.clk(clk), .nrst(nrst), .sclk(sclk), .sdata(sdata),
    .load_strobe(load_strobe), .power_enable(power_enable),
    .lock_indicator(lock_indicator), .r_latch(r_latch), .n_latch(n_latch),
    .func_latch(func_latch), .counter_reset(counter_reset),
    .power_down(power_down), .monitor_output(monitor_output));
  sll_host i_host (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
  // Core clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      finish_test;
    end
  end
  // Init arms one extra pulse on the next N write
  function automatic int exp_pulse(input logic [1:0] s, input bit a);
    return (s == sll_pkg::SEL_INIT || (s == sll_pkg::SEL_N && a)) ? 2 : 0;
  endfunction
  task automatic wr(input logic [23:0] w, input bit ex);
    int hi;
    hi = 0;
    @(posedge clk);
    power_enable <= 1'($urandom);
    i_host.send(w, 8'($urandom), ex, 1'($urandom));
    repeat (12) begin
      @(posedge clk);
      #1 hi += int'(counter_reset === 1'b1);
    end
    `CHK("pulse", exp_pulse(w[1:0], arm), hi)
    if (w[1:0] == sll_pkg::SEL_INIT) arm = 1'b1;
    else if (w[1:0] == sll_pkg::SEL_N) arm = 1'b0;
    case (w[1:0])
      sll_pkg::SEL_R: er = w;
      sll_pkg::SEL_N: en = w;
      default: ef = w;
    endcase
    `CHK("r_latch", er, r_latch)
    `CHK("n_latch", en, n_latch)
    `CHK("func_latch", ef, func_latch)
    `CHK("power_down", ~power_enable, power_down)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    power_enable = 1'b0;
    lock_indicator = 1'b0;
    er = sll_pkg::LATCH_RST;
    en = sll_pkg::LATCH_RST;
    ef = sll_pkg::LATCH_RST;
    void'($urandom(40923));
    repeat (10) @(posedge clk);
    `CHK("func_latch", ef, func_latch)
    `CHK("power_down", 1'b1, power_down)
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    $display("test reset done");
    wr(24'h123473, 1'b0);
    wr(24'h000072, 1'b0);
    wr(24'h00A00C, 1'b1);
    wr(24'h0158A1, 1'b0);
    wr(24'h0158A5, 1'b0);
    `CHK("monitor", 1'b1, monitor_output)
    $display("test power-up order done");
    for (int i = 0; i < 20; i++) wr(24'($urandom), 1'($urandom));
    $display("test random words done");
    wr(24'h000016, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      lock_indicator <= ~lock_indicator;
      repeat (5) @(posedge clk);
      #1 `CHK("monitor", lock_indicator, monitor_output)
    end
    $display("test lock monitor done");
    finish_test;
  end
endmodule // sll_top_tb
`default_nettype wire
